// >>> logic/gsttc_timer.v
// gated sixteen-bit timer/counter with ahb-lite slave, prescaler and interrupt
`timescale 1ns/100ps
`default_nettype none
`include "gsttc_map.vh"
// Function
// - sixteen-bit up-counter in high and low bytes
// - byte write replaces counter contents at once
// - on and gate enable decide counting
// - three-bit field selects the counter clock
// - instruction clock counts once per cycle, prescaled
// - oscillator source adds four per instruction cycle
// - external rising edges count, synced or not
// - first external rising edge needs preceding falling edge
// - prescaler divides by one, two, four, eight
// - prescaler hidden, cleared on counter write
// - secondary oscillator enable, shareable, runs in sleep
// - synchroniser stops in sleep, async wakes
// - all-ones wraps to zero, sets rollover flag
// - gated counting follows gate polarity level
// - async bit bypasses input synchronisation
module gsttc_timer #(
  parameter INSTR_DIV = 4, // system clocks per instruction cycle
  parameter SOSC_START_CYCLES = 100000 // oscillator start-up in clk cycles
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // count inputs
  input wire external_count_input,
  input wire gate_in,
  input wire crystal_input_pin,
  // oscillator and sleep
  output reg crystal_drive_pin,
  output reg sosc_clk_out,
  output reg irq
);
  localparam SOSC_HALF = `GSTTC_CLK_HZ / (2 * `GSTTC_SOSC_HZ); // half period in clk cycles

  reg [7:0] count_low_byte_r; // low counter byte
  reg [7:0] count_high_byte_r; // high counter byte
  reg [10:0] ctrl_r; // control fields
  reg roll_r; // rollover_flag sticky
  reg [1:0] mask_r; // interrupt mask
  reg [2:0] ps_cnt_r; // hidden prescale counter
  reg [1:0] iphase_r; // instruction cycle phase
  reg armed_r; // falling edge seen since arm condition
  reg on_d_r; // previous on bit
  reg [9:0] sosc_div_r; // secondary oscillator divider
  reg sosc_r; // secondary oscillator level
  reg [16:0] sosc_start_r; // start-up counter
  reg sosc_rdy_r; // oscillator ready
  reg ext_d_r; // async path previous sample
  reg ph_wr_r; // data phase write pending
  reg ph_rd_r; // data phase read pending
  reg [11:0] ph_addr_r; // latched address
  wire [15:0] count_value;
  wire ext_lvl;
  wire ext_rise;
  wire ext_fall;
  wire on_bit;
  wire gate_count_select;
  wire gate_polarity;
  wire async_bit;
  wire [1:0] prescale_select;
  wire [2:0] clk_sel;
  wire secondary_osc_enable;
  wire sleep_bit;
  wire run;
  wire async_rise;
  wire async_fall;
  wire src_rise;
  wire src_fall;
  wire ps_tick;
  wire ahb_take;
  wire cnt_wr;
  wire [15:0] count_inc;
  wire [1:0] status_w;
  reg [2:0] steps; // increments this cycle

  // field aliases
  assign count_value = {count_high_byte_r, count_low_byte_r};
  assign on_bit = ctrl_r[`GSTTC_CTRL_ON];
  assign gate_count_select = ctrl_r[`GSTTC_CTRL_GATE_EN];
  assign gate_polarity = ctrl_r[`GSTTC_CTRL_GATE_POL];
  assign async_bit = ctrl_r[`GSTTC_CTRL_ASYNC];
  assign prescale_select = ctrl_r[`GSTTC_CTRL_PS_HI:`GSTTC_CTRL_PS_LO];
  assign clk_sel = ctrl_r[`GSTTC_CTRL_CS_HI:`GSTTC_CTRL_CS_LO];
  assign secondary_osc_enable = ctrl_r[`GSTTC_CTRL_SOSC_EN];
  assign sleep_bit = ctrl_r[`GSTTC_CTRL_SLEEP];
  assign status_w = {sosc_rdy_r, roll_r};

  // prescale terminal count for the selected ratio
  function ps_done;
    input [2:0] cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ps_done = 1'b1;
        2'h1: ps_done = (cnt[0] == 1'b1);
        2'h2: ps_done = (cnt[1:0] == 2'h3);
        default: ps_done = (cnt == 3'h7);
      endcase
    end
  endfunction

  // synchroniser for the external input, held in sleep
  gsttc_edge_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din(external_count_input & ~sleep_bit),
    .level(ext_lvl),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // async path samples the pin without the filter stages
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= external_count_input;
    end
  end
  // bypass: raw pin edge drives the counter; metastability traded for speed
  assign async_rise = external_count_input & ~ext_d_r;
  assign async_fall = ~external_count_input & ext_d_r;

  // on with gate follows the polarity-matched gate level
  assign run = on_bit & (~gate_count_select | (gate_in == gate_polarity));
  // synchronised gate with synchronised clock left to software

  // source edge selection
  assign src_rise = (clk_sel == `GSTTC_CS_INSTR) ? (iphase_r == 2'h3) :
                    (clk_sel == `GSTTC_CS_EXT) ? (async_bit ? async_rise : ext_rise) :
                    (clk_sel == `GSTTC_CS_SOSC) ? (sosc_div_r == 10'h000 & ~sosc_r) :
                    1'b0;
  assign src_fall = async_bit ? async_fall : ext_fall;
  assign ps_tick = run & src_rise & ps_done(ps_cnt_r, prescale_select) &
                   ((clk_sel != `GSTTC_CS_EXT) | armed_r);

  // count step: raw oscillator adds one per system clock
  always @* begin
    steps = 3'h0;
    if (run & (clk_sel == `GSTTC_CS_FOSC)) begin
      steps = 3'h1;
    end else if (ps_tick) begin
      steps = 3'h1;
    end
  end
  assign count_inc = count_value + {13'h0000, steps};

  // ahb-lite address phase capture
  assign ahb_take = hsel & hready & htrans[1];
  assign cnt_wr = ph_wr_r & ((ph_addr_r == `GSTTC_OFF_COUNT_LOW) |
                  (ph_addr_r == `GSTTC_OFF_COUNT_HIGH));

  // bus phase and zero wait-state response
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr_r <= ahb_take & hwrite;
      ph_rd_r <= ahb_take & ~hwrite;
      if (ahb_take) begin
        ph_addr_r <= {haddr[11:2], 2'h0};
      end
    end
  end

  // read data registered in the address phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (ahb_take & ~hwrite) begin
      case ({haddr[11:2], 2'h0})
        `GSTTC_OFF_COUNT_LOW: hrdata <= {24'h000000, count_low_byte_r};
        `GSTTC_OFF_COUNT_HIGH: hrdata <= {24'h000000, count_high_byte_r};
        `GSTTC_OFF_CTRL: hrdata <= {21'h000000, ctrl_r};
        `GSTTC_OFF_STATUS: hrdata <= {30'h00000000, status_w};
        `GSTTC_OFF_MASK: hrdata <= {30'h00000000, mask_r};
        default: hrdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // counter, control, prescaler and flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_low_byte_r <= 8'h00;
      count_high_byte_r <= 8'h00;
      ctrl_r <= `GSTTC_CTRL_RESET;
      ps_cnt_r <= 3'h0;
      roll_r <= 1'b0;
      mask_r <= 2'h0;
      armed_r <= 1'b0;
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= on_bit;
      // prescaler advances on each enabled source edge
      if (cnt_wr) begin
        ps_cnt_r <= 3'h0;
      end else if (run & src_rise & ((clk_sel != `GSTTC_CS_EXT) | armed_r)) begin
        ps_cnt_r <= ps_done(ps_cnt_r, prescale_select) ? 3'h0 : ps_cnt_r + 3'h1;
      end
      // arm logic: write, disable or enable forces a falling edge first
      if (cnt_wr | ~on_bit | (on_bit & ~on_d_r)) begin
        armed_r <= 1'b0;
      end else if (src_fall) begin
        armed_r <= 1'b1;
      end
      // counter write replaces the byte immediately
      if (ph_wr_r & (ph_addr_r == `GSTTC_OFF_COUNT_LOW)) begin
        count_low_byte_r <= hwdata[7:0];
      end else if (ph_wr_r & (ph_addr_r == `GSTTC_OFF_COUNT_HIGH)) begin
        count_high_byte_r <= hwdata[7:0];
      end else if (steps != 3'h0) begin
        count_low_byte_r <= count_inc[7:0];
        count_high_byte_r <= count_inc[15:8];
      end
      // control and mask writes
      if (ph_wr_r & (ph_addr_r == `GSTTC_OFF_CTRL)) begin
        ctrl_r <= hwdata[10:0];
      end
      if (ph_wr_r & (ph_addr_r == `GSTTC_OFF_MASK)) begin
        mask_r <= hwdata[1:0];
      end
      // rollover set wins over write-one clear
      if ((steps != 3'h0) & (count_value == 16'hFFFF) & ~cnt_wr) begin
        roll_r <= 1'b1;
      end else if (ph_wr_r & (ph_addr_r == `GSTTC_OFF_STATUS) & hwdata[`GSTTC_ST_ROLL]) begin
        roll_r <= 1'b0;
      end
    end
  end

  // instruction cycle phase counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      iphase_r <= 2'h0;
    end else if (iphase_r == INSTR_DIV[1:0] - 2'h1) begin
      iphase_r <= 2'h0;
    end else begin
      iphase_r <= iphase_r + 2'h1;
    end
  end

  // secondary oscillator model: divider plus start-up timer, free of sleep
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sosc_div_r <= 10'h000;
      sosc_r <= 1'b0;
      sosc_start_r <= 17'h00000;
      sosc_rdy_r <= 1'b0;
    end else if (~secondary_osc_enable) begin
      sosc_div_r <= 10'h000;
      sosc_r <= 1'b0;
      sosc_start_r <= 17'h00000;
      sosc_rdy_r <= 1'b0;
    end else begin
      // keeps running in sleep
      if (sosc_div_r == SOSC_HALF[9:0] - 10'h001) begin
        sosc_div_r <= 10'h000;
        sosc_r <= ~sosc_r;
      end else begin
        sosc_div_r <= sosc_div_r + 10'h001;
      end
      // ready status for software polling
      if (sosc_start_r == SOSC_START_CYCLES[16:0]) begin
        sosc_rdy_r <= 1'b1;
      end else begin
        sosc_start_r <= sosc_start_r + 17'h00001;
      end
    end
  end

  // registered outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crystal_drive_pin <= 1'b0;
      sosc_clk_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      crystal_drive_pin <= secondary_osc_enable & ~crystal_input_pin;
      sosc_clk_out <= sosc_r; // shared with other modules
      irq <= |(status_w & mask_r & 2'h1);
    end
  end
endmodule // gsttc_timer
`default_nettype wire

// >>> inc/gsttc_map.vh
// register map, field positions, reset values and timing constants of the gated timer
`ifndef GSTTC_MAP_VH
`define GSTTC_MAP_VH
// byte offsets of the word registers
`define GSTTC_OFF_COUNT_LOW 12'h000
`define GSTTC_OFF_COUNT_HIGH 12'h004
`define GSTTC_OFF_CTRL 12'h008
`define GSTTC_OFF_STATUS 12'h00C
`define GSTTC_OFF_MASK 12'h010
// control register fields
`define GSTTC_CTRL_ON 0
`define GSTTC_CTRL_GATE_EN 1
`define GSTTC_CTRL_GATE_POL 2
`define GSTTC_CTRL_ASYNC 3
`define GSTTC_CTRL_PS_LO 4
`define GSTTC_CTRL_PS_HI 5
`define GSTTC_CTRL_CS_LO 6
`define GSTTC_CTRL_CS_HI 8
`define GSTTC_CTRL_SOSC_EN 9
`define GSTTC_CTRL_SLEEP 10
`define GSTTC_CTRL_RESET 11'h000
// status bits
`define GSTTC_ST_ROLL 0
`define GSTTC_ST_SOSC_RDY 1
// clock source codes
`define GSTTC_CS_INSTR 3'h0
`define GSTTC_CS_FOSC 3'h1
`define GSTTC_CS_EXT 3'h2
`define GSTTC_CS_SOSC 3'h3
// clock figures
`define GSTTC_CLK_HZ 50000000
`define GSTTC_SOSC_HZ 32768
`define GSTTC_SOSC_START_MS 2
`endif

// >>> logic/gsttc_edge_sync.v
// three-stage input synchroniser with agreement-based edge detection
`timescale 1ns/100ps
`default_nettype none
module gsttc_edge_sync (
  // clock and reset
  input wire clk,
  input wire rst,
  // raw input and conditioned outputs
  input wire din,
  output wire level,
  output wire rise,
  output wire fall
);
  reg s1_r; // first stage, read only by s2
  reg s2_r;
  reg s3_r;
  reg lvl_r; // accepted level
  wire agree;

  // shift chain
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        lvl_r <= s2_r;
      end
    end
  end

  assign agree = (s2_r == s3_r);
  assign level = lvl_r;
  // a change counts once stage two and three agree
  assign rise = agree & s2_r & ~lvl_r;
  assign fall = agree & ~s2_r & lvl_r;
endmodule // gsttc_edge_sync
`default_nettype wire

// >>> sim/gsttc_chk.sv
// bus and pin checker for the gated timer
`timescale 1ns/100ps
`default_nettype none
`include "gsttc_map.vh"
module gsttc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus side
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic crystal_input_pin,
  input wire logic crystal_drive_pin,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // transfer taken at this edge, and its write flavour
  wire logic tk = hsel & hready & htrans[1];
  wire logic wtk = tk & hwrite;
  // read address phase at a given offset
  sequence s_rd(logic [11:0] a);
    tk && !hwrite && haddr == a;
  endsequence
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_unmapped;
    s_rd(12'h020) |=> hrdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_byte;
    s_rd(`GSTTC_OFF_COUNT_LOW) or s_rd(`GSTTC_OFF_COUNT_HIGH) |=> hrdata[31:8] == 24'h000000;
  endproperty
  a_byte: assert property (p_byte) else $error("count byte too wide");
  property p_ctrl;
    s_rd(`GSTTC_OFF_CTRL) |=> hrdata[31:11] == 21'h000000;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read too wide");
  property p_flags;
    s_rd(`GSTTC_OFF_STATUS) or s_rd(`GSTTC_OFF_MASK) |=> hrdata[31:2] == 30'h00000000;
  endproperty
  a_flags: assert property (p_flags) else $error("flag read too wide");
  // irq only drops after a status or mask write lands
  property p_irq_off;
    $fell(irq) |-> $past(wtk, 2) || $past(wtk, 3);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq dropped unprompted");
  property p_xtal;
    crystal_drive_pin |-> $past(crystal_input_pin) == 1'b0;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal drive not inverted");
endmodule // gsttc_chk
bind gsttc_timer gsttc_chk gsttc_chk_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .crystal_input_pin(crystal_input_pin),
  .crystal_drive_pin(crystal_drive_pin), .irq(irq));
`default_nettype wire

// >>> sim/gsttc_pin_model.sv
// far-side model: count pin source and crystal resonator
`timescale 1ns/100ps
`default_nettype none
module gsttc_pin_model (
  // count pin
  output var logic external_count_input,
  // crystal pins
  input wire logic crystal_drive_pin,
  output var logic crystal_input_pin
);
  // pin idles low between pulse trains
  initial external_count_input = 1'b0;
  initial crystal_input_pin = 1'b0;
  // resonator lags the amplifier, so the loop keeps swinging
  always @(crystal_drive_pin) crystal_input_pin <= #30 crystal_drive_pin;
  // n pulses, w ns per level, ending low
  task automatic pulses(input int n, input int w);
    // start off the clock edge so the pin never races the sampling flops
    #7;
    repeat (n) begin
      #w external_count_input = 1'b1;
      #w external_count_input = 1'b0;
    end
  endtask
endmodule // gsttc_pin_model
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the gated timer
`timescale 1ns/100ps
`default_nettype none
`include "gsttc_map.vh"
module tb;
  localparam logic [11:0] LO = `GSTTC_OFF_COUNT_LOW;
  localparam logic [11:0] HI = `GSTTC_OFF_COUNT_HIGH;
  localparam logic [11:0] CT = `GSTTC_OFF_CTRL;
  localparam logic [11:0] ST = `GSTTC_OFF_STATUS;
  localparam logic [11:0] MK = `GSTTC_OFF_MASK;
  // drives and observed values
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, gate_in = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h00000000, rd, c;
  wire logic [31:0] hrdata;
  wire logic hreadyout, ext_pin, xin, xout, irq, sosc_out;
  int mismatches = 0, tests_run = 0, cycles = 0;
  always #10 clk = ~clk;
  // short oscillator start keeps the run brief
  gsttc_timer #(.SOSC_START_CYCLES(20)) gsttc_timer_inst (.clk(clk), .rst(rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .external_count_input(ext_pin), .gate_in(gate_in), .crystal_input_pin(xin),
    .crystal_drive_pin(xout), .sosc_clk_out(sosc_out), .irq(irq));
  gsttc_pin_model gsttc_pin_model_inst (.external_count_input(ext_pin),
    .crystal_drive_pin(xout), .crystal_input_pin(xin));
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one single transfer; rd holds read data
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hwrite <= wr;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // x in g fails too
  task automatic chk_rng(input string n, input int lo, input int hi, input logic [31:0] g);
    tests_run++;
    if ((^g) === 1'bx || g < lo || g > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0h", n, lo, hi, g);
    end
  endtask
  task automatic rd_cnt(output logic [31:0] v);
    bus(1'b0, LO, 32'h0);
    v = {24'h0, rd[7:0]};
    bus(1'b0, HI, 32'h0);
    v[15:8] = rd[7:0];
  endtask
  // irq settles one clock after its cause
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic t_reset;
    bus(1'b0, CT, 32'h0);
    chk("ctrl", 32'h0, rd);
    rd_cnt(c);
    chk("count", 32'h0, c);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
  endtask
  // first rise after write is dropped, eight rises remain
  task automatic t_ext;
    for (int a = 0; a < 2; a++) begin
      for (int p = 0; p < 4; p++) begin
        bus(1'b1, CT, 32'h0);
        bus(1'b1, LO, 32'h0);
        bus(1'b1, HI, 32'h0);
        bus(1'b1, CT, {23'h0, 3'h2, p[1:0], a[0], 3'h1});
        gsttc_pin_model_inst.pulses(9, 120);
        bus(1'b1, CT, 32'h0);
        rd_cnt(c);
        chk("ext count", 32'h8 >> p, c);
      end
    end
    $display("test external done");
  endtask
  task automatic t_roll;
    bus(1'b1, MK, 32'h1);
    bus(1'b1, HI, 32'hFF);
    bus(1'b1, LO, 32'hFE);
    bus(1'b1, CT, 32'h81);
    gsttc_pin_model_inst.pulses(3, 120);
    rd_cnt(c);
    chk("wrap count", 32'h0, c);
    bus(1'b0, ST, 32'h0);
    chk("status", 32'h1, rd);
    irq_is(1'b1);
    bus(1'b1, MK, 32'h0);
    irq_is(1'b0);
    bus(1'b1, MK, 32'h1);
    irq_is(1'b1);
    bus(1'b1, ST, 32'h1);
    irq_is(1'b0);
    bus(1'b0, ST, 32'h0);
    chk("status clear", 32'h0, rd);
    $display("test rollover done");
  endtask
  // sleep stops the synchroniser; only the bypass path still counts
  task automatic t_sleep;
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, CT, 32'h0);
      bus(1'b1, LO, 32'h0);
      bus(1'b1, CT, {21'h0, 1'b1, 1'b0, 3'h2, 2'h0, a[0], 3'h1});
      gsttc_pin_model_inst.pulses(5, 120);
      bus(1'b1, CT, 32'h0);
      rd_cnt(c);
      chk("sleep count", (a == 1) ? 32'h4 : 32'h0, c);
    end
    $display("test sleep done");
  endtask
  // run, gated, off and instruction-clock cases over one window
  task automatic t_gate;
    int f[6] = '{1, 7, 7, 3, 2, 1};
    int g[6] = '{0, 0, 1, 0, 0, 0};
    int s[6] = '{1, 1, 1, 1, 1, 0};
    int lo[6] = '{38, 0, 38, 38, 0, 8};
    int hi[6] = '{48, 0, 48, 48, 0, 13};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, CT, 32'h0);
      bus(1'b1, LO, 32'h0);
      gate_in <= g[i][0]; // plain level, never a synced comparator
      bus(1'b1, CT, {23'h0, s[i][2:0], 2'h0, f[i][3:0]});
      repeat (40) @(posedge clk);
      bus(1'b1, CT, 32'h0);
      rd_cnt(c);
      chk_rng("gated count", lo[i], hi[i], c);
    end
    $display("test gate done");
  endtask
  task automatic t_sosc;
    int n = 0;
    int tg = 0;
    logic so_prev;
    bus(1'b1, CT, 32'h200);
    do begin
      bus(1'b0, ST, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 50);
    chk("osc ready", 32'h1, {31'h0, rd[1]});
    bus(1'b1, LO, 32'h0);
    bus(1'b1, CT, 32'h2C1);
    so_prev = sosc_out;
    // shared oscillator output toggles every 762 clocks
    repeat (4000) begin
      @(negedge clk);
      if (sosc_out !== so_prev) tg++;
      so_prev = sosc_out;
    end
    chk_rng("osc toggles", 4, 6, tg);
    bus(1'b1, CT, 32'h200);
    rd_cnt(c);
    chk_rng("osc count", 1, 3, c);
    $display("test oscillator done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_ext;
    t_roll;
    t_sleep;
    t_gate;
    t_sosc;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
